// file: hw/crba_chan_mem.sv
`timescale 1ns/1ps
module crba_chan_mem
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Access
    input wire logic wr_en,
    input wire crba_pkg::crba_addr_t addr,
    input wire crba_pkg::crba_word_t wr_data,
    // Outputs
    output crba_pkg::crba_word_t rd_data,
    output crba_pkg::crba_tone_s tone
);
    import crba_pkg::*;

    // Addresses 40..63 are never produced, so the array holds only 40 words
    crba_word_t mem [CRBA_WORDS];
    crba_word_t rd_reg;
    crba_tone_s tone_reg;

    always_ff @(posedge ref_clk)
    begin
        if (wr_en && addr < crba_addr_t'(CRBA_WORDS))
        begin
            mem[addr] <= wr_data;
        end
        rd_reg <= (addr < crba_addr_t'(CRBA_WORDS)) ? mem[addr] : CRBA_WORD_RST;
    end

    // Tone words shadowed in flops so the generators read them freely
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            tone_reg <= '0;
        end
        else if (wr_en)
        begin
            if (addr == CRBA_TONE1_AMP) tone_reg.tone1_amp <= wr_data; // RULE7
            if (addr == CRBA_TONE1_FREQ) tone_reg.tone1_freq <= wr_data; // RULE7
            if (addr == CRBA_TONE0_AMP) tone_reg.tone0_amp <= wr_data; // RULE8
            if (addr == CRBA_TONE0_FREQ) tone_reg.tone0_freq <= wr_data; // RULE8
        end
    end

    assign rd_data = rd_reg;
    assign tone = tone_reg;

    chk_tone1_amp: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE7
        wr_en && addr == CRBA_TONE1_AMP |=> tone.tone1_amp == $past(wr_data))
        else $error("tone 1 amplitude word not captured");
    chk_tone0_freq: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE8
        wr_en && addr == CRBA_TONE0_FREQ |=> tone.tone0_freq == $past(wr_data))
        else $error("tone 0 frequency word not captured");

endmodule

// file: hw/crba_pkg.sv
package crba_pkg;

    // ----------------------------------------------------------------
    // Memory geometry
    // ----------------------------------------------------------------
    localparam int CRBA_CHANNELS = 4;
    localparam int CRBA_WORDS = 40;
    localparam int CRBA_BLOCKS = 5;
    localparam int CRBA_BLOCK_WORDS = 8;
    localparam int CRBA_ADDR_W = 6;
    localparam int CRBA_DATA_W = 16;

    typedef logic [2:0] crba_block_t;
    typedef logic [2:0] crba_index_t;
    typedef logic [CRBA_ADDR_W-1:0] crba_addr_t;
    typedef logic [CRBA_DATA_W-1:0] crba_word_t;
    typedef logic [CRBA_CHANNELS-1:0] crba_chmask_t;

    // ----------------------------------------------------------------
    // Block codes
    // ----------------------------------------------------------------
    localparam crba_block_t CRBA_BLK_IMPEDANCE = 3'h0;
    localparam crba_block_t CRBA_BLK_ECHO = 3'h1;
    localparam crba_block_t CRBA_BLK_GAIN_TONE = 3'h2;
    localparam crba_block_t CRBA_BLK_TX = 3'h3;
    localparam crba_block_t CRBA_BLK_RX = 3'h4;
    localparam crba_block_t CRBA_BLK_LAST = 3'h4;

    // Word index walk and reset values
    localparam crba_index_t CRBA_INDEX_FIRST = 3'h7;
    localparam crba_index_t CRBA_INDEX_LAST = 3'h0;
    localparam crba_word_t CRBA_WORD_RST = 16'h0000;

    // Tone words, full 6-bit addresses
    localparam crba_addr_t CRBA_TONE1_AMP = 6'h17;
    localparam crba_addr_t CRBA_TONE1_FREQ = 6'h16;
    localparam crba_addr_t CRBA_TONE0_AMP = 6'h15;
    localparam crba_addr_t CRBA_TONE0_FREQ = 6'h14;

    typedef enum logic [1:0]
    {
        CRBA_IDLE = 2'b00,
        CRBA_WALK = 2'b01
    } crba_state_e;

    // Host command, one block transfer
    typedef struct packed
    {
        crba_block_t block;
        logic write;
        crba_chmask_t channels;
    } crba_cmd_s;

    // One word as it moves on the port
    typedef struct packed
    {
        logic valid;
        logic last;
        crba_addr_t addr;
        crba_word_t data;
    } crba_beat_s;

    typedef struct packed
    {
        crba_word_t tone1_amp;
        crba_word_t tone1_freq;
        crba_word_t tone0_amp;
        crba_word_t tone0_freq;
    } crba_tone_s;

endpackage

// file: hw/crba_top.sv
// Summary of operation
// RULE1: Forty words per channel, five blocks, 3-bit code.
// RULE2: Address is block code over word index.
// RULE3: Whole block transferred, index counts 7 down 0.
// RULE4: Host gives only the block code.
// RULE5: Fixed block assignment of filter and gain words.
// RULE6: Receive gain access always carries frequency correction.
// RULE7: Words 23, 22 hold tone 1 amplitude, frequency.
// RULE8: Words 21, 20 hold tone 0 amplitude, frequency.
// RULE9: Each channel owns its memory; only selected touched.
`timescale 1ns/1ps
module crba_top
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Command from the host control port
    input wire logic cmd_valid,
    input wire crba_pkg::crba_cmd_s cmd,
    output logic cmd_ready,
    // Write words, one per beat while walking
    input wire crba_pkg::crba_word_t wr_word,
    // Word stream out
    output crba_pkg::crba_beat_s beat,
    output crba_pkg::crba_word_t rd_word,
    // Status
    output logic cmd_error,
    output crba_pkg::crba_tone_s tone_words [crba_pkg::CRBA_CHANNELS]
);
    import crba_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed
    {
        crba_state_e state;
        logic ready;
        crba_cmd_s cmd;
        crba_index_t index;
        logic error;
        crba_beat_s beat;
        logic rd_pend;
        crba_chmask_t rd_sel;
    } crba_top_s;

    // Reset leaves the walker idle with ready already up for the first command
    localparam crba_top_s CRBA_TOP_RST = '{state: CRBA_IDLE, ready: 1'b1, default: '0};

    crba_top_s st_reg;
    crba_top_s st_next;
    crba_word_t rd_reg;
    crba_word_t ch_rd [CRBA_CHANNELS];
    crba_tone_s ch_tone [CRBA_CHANNELS];
    crba_addr_t walk_addr;
    logic walking;

    assign walking = st_reg.state == CRBA_WALK;
    // Host code on top, word index generated here
    assign walk_addr = {st_reg.cmd.block, st_reg.index}; // RULE2 RULE4

    always_comb
    begin
        st_next = st_reg;
        st_next.beat.valid = 1'b0;
        st_next.beat.last = 1'b0;
        st_next.rd_pend = 1'b0;
        unique case (st_reg.state)
            CRBA_IDLE:
            begin
                if (cmd_valid)
                begin
                    // Codes above the receive block name no memory and are refused
                    if (cmd.block > CRBA_BLK_LAST) // RULE1 RULE5
                    begin
                        st_next.error = 1'b1;
                    end
                    else
                    begin
                        st_next.error = 1'b0;
                        st_next.cmd = cmd;
                        st_next.index = CRBA_INDEX_FIRST; // RULE3
                        st_next.state = CRBA_WALK;
                    end
                end
            end
            CRBA_WALK:
            begin
                // Gain and correction share one block, so one walk covers both
                st_next.beat.valid = 1'b1; // RULE6
                st_next.beat.addr = walk_addr;
                st_next.beat.data = wr_word;
                st_next.rd_pend = ~st_reg.cmd.write;
                st_next.rd_sel = st_reg.cmd.channels;
                st_next.index = st_reg.index - 3'h1; // RULE3
                if (st_reg.index == CRBA_INDEX_LAST)
                begin
                    st_next.beat.last = 1'b1;
                    st_next.state = CRBA_IDLE;
                end
            end
        endcase
        if (st_reg.rd_pend)
        begin
            st_next.beat.data = rd_word_mux(st_reg.rd_sel);
        end
        // Ready kept in its own flop so the port comes straight from a register
        st_next.ready = st_next.state == CRBA_IDLE;
    end

    // Lowest selected channel answers a read
    function automatic crba_word_t rd_word_mux(input crba_chmask_t sel);
        crba_word_t w;
        w = CRBA_WORD_RST;
        for (int i = CRBA_CHANNELS - 1; i >= 0; i--)
        begin
            if (sel[i]) w = ch_rd[i];
        end
        return w;
    endfunction

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_reg <= CRBA_TOP_RST;
            rd_reg <= CRBA_WORD_RST;
        end
        else
        begin
            st_reg <= st_next;
            rd_reg <= st_reg.rd_pend ? rd_word_mux(st_reg.rd_sel) : rd_reg;
        end
    end

    // ----------------------------------------------------------------
    // Per-channel memories
    // ----------------------------------------------------------------
    for (genvar c = 0; c < CRBA_CHANNELS; c++)
    begin : g_ch
        crba_chan_mem u_mem
        (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .wr_en(walking && st_reg.cmd.write && st_reg.cmd.channels[c]), // RULE9
            .addr(walk_addr),
            .wr_data(wr_word),
            .rd_data(ch_rd[c]),
            .tone(ch_tone[c])
        );
    end

    // Tone outputs registered again so every output is a flop
    crba_tone_s tone_reg [CRBA_CHANNELS];
    always_ff @(posedge ref_clk)
    begin
        for (int c = 0; c < CRBA_CHANNELS; c++)
        begin
            tone_reg[c] <= sys_rst ? '0 : ch_tone[c];
        end
    end

    assign cmd_ready = st_reg.ready;
    assign beat = st_reg.beat;
    assign rd_word = rd_reg;
    assign cmd_error = st_reg.error;
    assign tone_words = tone_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence walk_start;
        !walking ##1 walking;
    endsequence
    sequence walk_body;
        walking [*8] ##1 !walking;
    endsequence

    chk_walk_eight: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE3
        walk_start |-> walk_body)
        else $error("block walk is not eight words long");
    chk_first_index: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE3
        walk_start |-> st_reg.index == 3'h7)
        else $error("walk does not start at word seven");
    chk_count_down: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE3
        walking && $past(walking) |-> st_reg.index == $past(st_reg.index) - 3'h1)
        else $error("word index does not count down");
    chk_addr_split: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE2
        beat.valid |-> beat.addr[5:3] == $past(st_reg.cmd.block))
        else $error("beat address upper bits differ from block code");
    chk_block_range: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE1
        cmd_valid && cmd_ready && cmd.block > 3'h4 |=> cmd_error && !walking)
        else $error("illegal block code accepted");
    chk_addr_limit: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE5
        beat.valid |-> beat.addr < 6'h28)
        else $error("beat address beyond forty words");
    chk_rx_pair: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE6
        beat.valid && beat.addr == 6'h27 |-> ##4 beat.valid && beat.addr == 6'h23)
        else $error("receive gain walk skipped correction words");
    chk_chan_gate: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE9
        walking && !st_reg.cmd.channels[0] |-> !g_ch[0].u_mem.wr_en)
        else $error("unselected channel written");
    chk_last_flag: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE3
        beat.last |-> beat.valid && beat.addr[2:0] == 3'h0)
        else $error("last beat not at word zero");
    chk_ready_flop: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE3
        cmd_ready != walking)
        else $error("ready does not track the walker");
    chk_beat_follow: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE3
        beat.valid == $past(walking))
        else $error("beat issued outside a walk cycle");
    chk_first_word: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE3
        walk_start |=> beat.valid && beat.addr[2:0] == 3'h7)
        else $error("first beat is not the highest word");
    chk_good_clear: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE1
        cmd_valid && cmd_ready && cmd.block <= 3'h4 |=> !cmd_error && walking)
        else $error("legal block code not taken");
    chk_error_hold: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE1
        !(cmd_valid && cmd_ready) |=> $stable(cmd_error))
        else $error("error flag moved without a command");

endmodule

// file: verification/crba_host_model.sv
`timescale 1ns/1ps
module crba_host_model
(
    // Clock
    input wire logic ref_clk,
    // Command port
    input wire logic cmd_ready,
    output logic cmd_valid,
    output crba_pkg::crba_cmd_s cmd
);
    import crba_pkg::*;

    initial
    begin
        cmd_valid = 1'b0;
        cmd = '0;
    end

    // Called at a falling edge; returns at the falling edge after the take
    task automatic send(input crba_block_t b, input logic w, input crba_chmask_t ch,
        output logic ok);
        int n;
        n = 0;
        cmd_valid = 1'b1;
        cmd = '{block: b, write: w, channels: ch};
        while (cmd_ready !== 1'b1 && n < 20)
        begin
            @(negedge ref_clk);
            n++;
        end
        ok = (n < 20);
        @(posedge ref_clk);
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        // Released fields flip so a stale command never looks valid
        cmd = ~cmd;
    endtask
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import crba_pkg::*;

    logic ref_clk;
    logic sys_rst;
    logic cmd_ready;
    logic cmd_valid;
    logic cmd_error;
    crba_cmd_s cmd;
    crba_word_t wr_word;
    crba_word_t rd_word;
    crba_beat_s beat;
    crba_tone_s tw [CRBA_CHANNELS];
    crba_word_t shadow [CRBA_CHANNELS][CRBA_WORDS];
    int n_fail = 0;
    int checks_done = 0;

    crba_top u_crba_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .wr_word(wr_word), .beat(beat),
        .rd_word(rd_word), .cmd_error(cmd_error), .tone_words(tw));
    crba_host_model u_crba_host_model (.ref_clk(ref_clk), .cmd_ready(cmd_ready),
        .cmd_valid(cmd_valid), .cmd(cmd));

    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task automatic cmp_v(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks=%0d fails=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_tone;
        crba_tone_s e;
        for (int c = 0; c < CRBA_CHANNELS; c++)
        begin
            e = {shadow[c][23], shadow[c][22], shadow[c][21], shadow[c][20]};
            cmp_v(tw[c], e);
        end
    endtask

    // ----------------------------------------------------------------
    // One block transfer, every beat judged
    // ----------------------------------------------------------------
    task automatic walk(input crba_block_t b, input logic w, input crba_chmask_t ch,
        input crba_word_t base);
        logic ok;
        int lo;
        crba_index_t ix;
        lo = 0;
        while (!ch[lo])
            lo++;
        u_crba_host_model.send(b, w, ch, ok);
        if (!ok)
        begin
            n_fail++;
            stop_test();
        end
        cmp_v(cmd_ready, 1'b0);
        for (int k = 1; k <= 10; k++)
        begin
            if (k <= 8)
            begin
                ix = 3'(8 - k);
                wr_word = base ^ {13'h0000, ix};
                for (int c = 0; c < CRBA_CHANNELS; c++)
                    if (w && ch[c])
                        shadow[c][{b, ix}] = wr_word;
            end
            if (k >= 2 && k <= 9)
            begin
                cmp_v(beat.valid, 1'b1);
                cmp_v(beat.addr, {b, 3'(9 - k)});
                cmp_v(beat.last, k == 9);
                if (w || k >= 3)
                    cmp_v(beat.data, shadow[lo][{b, 3'(w ? 9 - k : 10 - k)}]);
            end
            if (k == 10)
                cmp_v(beat.valid, 1'b0);
            if (!w && k >= 3)
                cmp_v(rd_word, shadow[lo][{b, 3'(10 - k)}]);
            @(negedge ref_clk);
        end
        cmp_v(cmd_error, 1'b0);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic s_blocks;
        for (int b = 0; b < CRBA_BLOCKS; b++)
            walk(3'(b), 1'b1, 4'hF, 16'h1000 * 16'(b + 1));
        for (int b = 0; b < CRBA_BLOCKS; b++)
            walk(3'(b), 1'b0, 4'h1, 16'h0000);
        chk_tone();
    endtask

    task automatic s_chan;
        walk(3'h2, 1'b1, 4'h6, 16'hA5A0);
        chk_tone();
        walk(3'h2, 1'b0, 4'hC, 16'h0000);
    endtask

    // Codes past the last block must be refused without a walk
    task automatic s_bad;
        logic ok;
        for (int b = 5; b < 8; b++)
        begin
            u_crba_host_model.send(3'(b), 1'b0, 4'h1, ok);
            cmp_v(ok, 1'b1);
            for (int k = 0; k < 10; k++)
            begin
                cmp_v(beat.valid, 1'b0);
                @(negedge ref_clk);
            end
            cmp_v(cmd_error, 1'b1);
        end
        walk(3'h4, 1'b0, 4'h1, 16'h0000);
    endtask

    initial
    begin
        #200000;
        n_fail++;
        stop_test();
    end

    initial
    begin
        sys_rst = 1'b1;
        wr_word = 16'h0000;
        repeat (20) @(negedge ref_clk);
        sys_rst = 1'b0;
        cmp_v(cmd_ready, 1'b1);
        cmp_v(beat, '0);
        cmp_v(cmd_error, 1'b0);
        for (int c = 0; c < CRBA_CHANNELS; c++)
            cmp_v(tw[c], 64'h0);
        s_blocks();
        s_chan();
        s_bad();
        stop_test();
    end
endmodule
